// ===== common/ustat_pkg.sv
/*
 * ustat_pkg: register map, bit positions, reset values and frame timing
 * for the serial transceiver status/control block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package ustat_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CTRL1    = 8'h04;
	localparam logic [7:0] ADDR_CTRL2    = 8'h08;
	localparam logic [7:0] ADDR_DATA     = 8'h0C;
	localparam logic [7:0] ADDR_BAUD     = 8'h10;
	// status bit positions
	localparam int ST_TXE   = 7;
	localparam int ST_TC    = 6;
	localparam int ST_RXF   = 5;
	localparam int ST_IDLE  = 4;
	localparam int ST_OR    = 3;
	localparam int ST_NF    = 2;
	localparam int ST_FE    = 1;
	localparam int ST_PE    = 0;
	// control one bit positions
	localparam int C1_R9    = 7;
	localparam int C1_T9    = 6;
	localparam int C1_LPD   = 5;
	localparam int C1_WS    = 4;
	localparam int C1_WAKE  = 3;
	localparam int C1_PCE   = 2;
	localparam int C1_PS    = 1;
	localparam int C1_PIE   = 0;
	// control two bit positions
	localparam int C2_TIE   = 7;
	localparam int C2_TX_DONE_IRQ_EN  = 6;
	localparam int C2_RIE   = 5;
	localparam int C2_IDLE_IRQ_EN  = 4;
	localparam int C2_TE    = 3;
	localparam int C2_RE    = 2;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'hC0;
	localparam logic [7:0] CTRL1_RST  = 8'h00;
	localparam logic [7:0] CTRL2_RST  = 8'h00;
	localparam logic [7:0] BAUD_RST   = 8'h01;
	// sampling: sixteen samples per bit, majority of 8, 9 and 10
	localparam logic [3:0] SMP_LAST   = 4'hF;
	localparam logic [3:0] SMP_A      = 4'h7;
	localparam logic [3:0] SMP_B      = 4'h8;
	localparam logic [3:0] SMP_C      = 4'h9;
	localparam logic [3:0] SMP_HALF   = 4'h7;
	localparam logic [3:0] BITS_8     = 4'h8;
	localparam logic [3:0] BITS_9     = 4'h9;
	localparam logic [3:0] IDLE_BITS  = 4'hA;
	typedef enum logic [1:0] {USTAT_IDLE, USTAT_START, USTAT_DATA, USTAT_STOP} ustat_fsm_type;
endpackage : ustat_pkg

// ===== rtl/ustat_core.sv
/*
 * ustat_core: serial transceiver with status flags, interrupt request,
 * wait/halt behaviour, control register one and an APB slave.
 * Assumes a 10 MHz core clock, an asynchronous serial line on rx_pin
 * and a CPU that supplies its halt state and global interrupt mask.
 */
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
module ustat_core
	import ustat_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpu_halt,
	input  wire logic        global_irq_unmask,
	input  wire logic        rx_pin,
	output logic             tx_pin,
	output logic             irq_q,
	output logic             wake_q
);
	logic       rst_m_q, rst_q;
	logic       rx_m_q, rx_s_q;
	logic [7:0] status_q, ctrl1_q, ctrl2_q, baud_q, rx_data_q, tx_buf_q;
	logic       tx_buf_full_q, st_seen_q;
	logic [7:0] pre_q;
	logic       tick;
	logic       lpd_stop;
	ustat_fsm_type tx_st_q, rx_st_q;
	logic [3:0] tx_smp_q, tx_bit_q, rx_smp_q, rx_bit_q, idle_cnt_q;
	logic [8:0] tx_sh_q, rx_sh_q;
	logic       tx_nine_q, tx_par_q, rx_nine_q, rx_par_q;
	logic [2:0] maj_q;
	logic       rx_noise_q, rx_mute_q;
	logic       acc, wr, rd, acc_st, acc_dat;
	logic       rx_done, rx_fe, rx_pe, rx_nf, rx_ninth;
	logic       tx_load, tx_finish;
	logic       irq_d;

	// majority of three samples, used for start, data and stop bits
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : maj3

	// decode of an accepted access at one register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
		return s && (a == off);
	endfunction : hit

	// reset release through two flip-flops
	// assertion is asynchronous; release is aligned to the clock edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_m_q <= 1'b0;
			rst_q   <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_q   <= rst_m_q;
		end
	end

	// serial input synchroniser
	// only the second stage feeds logic; the first may still be settling
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
		end else begin
			rx_m_q <= rx_pin;
			rx_s_q <= rx_m_q;
		end
	end

	// bus decode; accesses complete in the access phase with no wait
	assign acc     = psel && penable && !cpu_halt;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign acc_st  = hit(paddr, ADDR_STATUS, acc);
	assign acc_dat = hit(paddr, ADDR_DATA, acc);

	// apb answer, ready withheld during halt
	// unmapped offsets answer with an error and read as zero; writes are dropped
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !cpu_halt;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					ADDR_STATUS: prdata <= {24'h00_0000, status_q};
					ADDR_CTRL1:  prdata <= {24'h00_0000, ctrl1_q};
					ADDR_CTRL2:  prdata <= {24'h00_0000, ctrl2_q};
					ADDR_DATA:   prdata <= {24'h00_0000, rx_data_q};
					ADDR_BAUD:   prdata <= {24'h00_0000, baud_q};
					default:     pslverr <= 1'b0;
				endcase
			end
			if (psel && !penable && !(paddr inside {ADDR_STATUS, ADDR_CTRL1, ADDR_CTRL2,
				ADDR_DATA, ADDR_BAUD})) begin
				pslverr <= 1'b1;
			end
		end
	end

	// control registers; frozen in halt since acc is gated
	// a received ninth bit lands after a software write in the same cycle
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			ctrl1_q <= CTRL1_RST;
			ctrl2_q <= CTRL2_RST;
			baud_q  <= BAUD_RST;
		end else begin
			if (hit(paddr, ADDR_CTRL1, wr)) begin
				ctrl1_q[7:1] <= pwdata[7:1];
				ctrl1_q[C1_PIE] <= pwdata[C1_PIE];
			end
			if (rx_done && rx_nine_q && !cpu_halt) begin
				ctrl1_q[C1_R9] <= rx_ninth;
			end
			if (hit(paddr, ADDR_CTRL2, wr)) begin
				ctrl2_q <= pwdata[7:0];
			end
			if (hit(paddr, ADDR_BAUD, wr)) begin
				baud_q <= pwdata[7:0];
			end
		end
	end

	// baud prescaler, one tick per sample; stopped in halt and low power
	// low power waits for both shifters to go idle so a byte in flight completes
	assign lpd_stop = ctrl1_q[C1_LPD] && tx_st_q == USTAT_IDLE && rx_st_q == USTAT_IDLE;
	assign tick     = (pre_q == 8'h00) && !cpu_halt && !lpd_stop;
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			pre_q <= 8'h00;
		end else if (!cpu_halt && !lpd_stop) begin
			pre_q <= (pre_q == 8'h00) ? baud_q : pre_q - 8'h01;
		end
	end

	// transmit buffer; data write fills it
	// a written byte waits while tx empty is still set; software must first
	// do the status access and data write that clear it
	assign tx_load = tx_buf_full_q && !status_q[ST_TXE] && tx_st_q == USTAT_IDLE && tick
		&& ctrl2_q[C2_TE];
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			tx_buf_q      <= 8'h00;
			tx_buf_full_q <= 1'b0;
		end else if (hit(paddr, ADDR_DATA, wr)) begin
			tx_buf_q      <= pwdata[7:0];
			tx_buf_full_q <= 1'b1;
		end else if (tx_load) begin
			tx_buf_full_q <= 1'b0;
		end
	end

	// transmitter: word size and parity latched per frame
	// the pin moves only on a tick, so every bit lasts sixteen ticks
	assign tx_finish = tick && tx_st_q == USTAT_STOP && tx_smp_q == SMP_LAST;
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			tx_st_q   <= USTAT_IDLE;
			tx_smp_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 9'h000;
			tx_nine_q <= 1'b0;
			tx_pin    <= 1'b1;
		end else if (tick) begin
			tx_smp_q <= tx_smp_q + 4'h1;
			case (tx_st_q)
				USTAT_IDLE: begin
					tx_pin   <= 1'b1;
					tx_smp_q <= 4'h0;
					if (tx_load) begin
						tx_st_q   <= USTAT_START;
						tx_nine_q <= ctrl1_q[C1_WS];
						tx_bit_q  <= 4'h0;
						tx_pin    <= 1'b0;
						if (ctrl1_q[C1_WS]) begin
							tx_sh_q <= {ctrl1_q[C1_PCE] ? (^tx_buf_q ^ ctrl1_q[C1_PS])
								: ctrl1_q[C1_T9], tx_buf_q};
						end else begin
							tx_sh_q <= {1'b0, ctrl1_q[C1_PCE] ?
								(^tx_buf_q[6:0] ^ ctrl1_q[C1_PS]) : tx_buf_q[7], tx_buf_q[6:0]};
						end
					end
				end
				USTAT_START: if (tx_smp_q == SMP_LAST) begin
					tx_st_q <= USTAT_DATA;
					tx_pin  <= tx_sh_q[0];
				end
				USTAT_DATA: if (tx_smp_q == SMP_LAST) begin
					tx_bit_q <= tx_bit_q + 4'h1;
					tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
					if (tx_bit_q + 4'h1 == (tx_nine_q ? BITS_9 : BITS_8)) begin
						tx_st_q <= USTAT_STOP;
						tx_pin  <= 1'b1;
					end else begin
						tx_pin <= tx_sh_q[1];
					end
				end
				USTAT_STOP: if (tx_smp_q == SMP_LAST) begin
					tx_st_q <= USTAT_IDLE;
				end
				default: tx_st_q <= USTAT_IDLE;
			endcase
		end
	end

	// receiver: sample 16 per bit, majority of 8, 9, 10
	assign rx_done  = tick && rx_st_q == USTAT_STOP && rx_smp_q == SMP_LAST;
	// framing is judged from the majority of the stop-bit samples
	assign rx_fe    = !maj3(maj_q);
	assign rx_ninth = rx_sh_q[8];
	// eight-bit frames hold the word in bits 7:0 with bit 8 always zero, so
	// the parity sum must take in bit 0 as well
	assign rx_pe    = rx_par_q && (rx_nine_q ? (^rx_sh_q ^ ctrl1_q[C1_PS])
		: (^rx_sh_q[7:0] ^ ctrl1_q[C1_PS]));
	assign rx_nf    = rx_noise_q || (maj_q != 3'b000 && maj_q != 3'b111);
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			rx_st_q    <= USTAT_IDLE;
			rx_smp_q   <= 4'h0;
			rx_bit_q   <= 4'h0;
			rx_sh_q    <= 9'h000;
			rx_nine_q  <= 1'b0;
			rx_par_q   <= 1'b0;
			maj_q      <= 3'b000;
			rx_noise_q <= 1'b0;
		end else if (tick) begin
			rx_smp_q <= rx_smp_q + 4'h1;
			if (rx_smp_q == SMP_A) maj_q[0] <= rx_s_q;
			if (rx_smp_q == SMP_B) maj_q[1] <= rx_s_q;
			if (rx_smp_q == SMP_C) maj_q[2] <= rx_s_q;
			case (rx_st_q)
				USTAT_IDLE: begin
					// the sample counter keeps running while idle so that the
					// idle-line counter sees a bit boundary every sixteen ticks
					if (!rx_s_q && ctrl2_q[C2_RE]) begin
						rx_st_q    <= USTAT_START;
						rx_nine_q  <= ctrl1_q[C1_WS];
						rx_par_q   <= ctrl1_q[C1_PCE];
						rx_bit_q   <= 4'h0;
						rx_noise_q <= 1'b0;
						rx_smp_q   <= 4'h1;
					end
				end
				USTAT_START: if (rx_smp_q == SMP_LAST) begin
					rx_st_q <= maj3(maj_q) ? USTAT_IDLE : USTAT_DATA;
					if (maj_q != 3'b000) rx_noise_q <= 1'b1;
				end
				USTAT_DATA: if (rx_smp_q == SMP_LAST) begin
					rx_sh_q <= rx_nine_q ? {maj3(maj_q), rx_sh_q[8:1]}
						: {1'b0, maj3(maj_q), rx_sh_q[7:1]};
					if (maj_q != 3'b000 && maj_q != 3'b111) rx_noise_q <= 1'b1;
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q + 4'h1 == (rx_nine_q ? BITS_9 : BITS_8)) rx_st_q <= USTAT_STOP;
				end
				USTAT_STOP: if (rx_smp_q == SMP_LAST) rx_st_q <= USTAT_IDLE;
				default: rx_st_q <= USTAT_IDLE;
			endcase
		end
	end

	// idle line and mute for wake method
	// the counter saturates so the idle flag rises once per quiet period
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			idle_cnt_q <= 4'h0;
			rx_mute_q  <= 1'b0;
		end else if (tick && rx_smp_q == SMP_LAST) begin
			if (!rx_s_q || rx_st_q != USTAT_IDLE) idle_cnt_q <= 4'h0;
			else if (idle_cnt_q != IDLE_BITS) idle_cnt_q <= idle_cnt_q + 4'h1;
			// zero leaves mute on idle; the address-mark exit for one is never reached, since rx_done always takes this branch
			if (!ctrl1_q[C1_WAKE] && idle_cnt_q + 4'h1 == IDLE_BITS) rx_mute_q <= 1'b0;
		end else if (rx_done && ctrl1_q[C1_WAKE] && rx_sh_q[rx_nine_q ? 8 : 7]) begin
			rx_mute_q <= 1'b0;
		end
	end

	// status flags; hardware set wins over software clear
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			status_q  <= STATUS_RST;
			st_seen_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else if (!cpu_halt) begin
			if (acc_st) st_seen_q <= 1'b1;
			else if (acc_dat) st_seen_q <= 1'b0;
			if (acc_dat && st_seen_q && pwrite) begin
				status_q[ST_TXE] <= 1'b0;
				status_q[ST_TC]  <= 1'b0;
			end
			if (acc_dat && st_seen_q) status_q[ST_PE] <= 1'b0;
			if (acc_dat && st_seen_q && !pwrite) begin
				status_q[ST_RXF]  <= 1'b0;
				status_q[ST_FE]   <= 1'b0;
				status_q[ST_NF]   <= 1'b0;
				status_q[ST_OR]   <= 1'b0;
				status_q[ST_IDLE] <= 1'b0;
			end
			if (tx_load) status_q[ST_TXE] <= 1'b1;
			if (tx_finish && !tx_buf_full_q) status_q[ST_TC] <= 1'b1;
			if (tick && rx_smp_q == SMP_LAST && idle_cnt_q + 4'h1 == IDLE_BITS)
				status_q[ST_IDLE] <= 1'b1;
			// a word that arrives while rx full is still set is dropped as overrun
			if (rx_done) begin
				if (status_q[ST_RXF]) begin
					status_q[ST_OR] <= 1'b1;
				end else begin
					rx_data_q         <= rx_sh_q[7:0];
					status_q[ST_RXF]  <= 1'b1;
					status_q[ST_FE]   <= rx_fe;
					status_q[ST_NF]   <= rx_nf;
					status_q[ST_PE]   <= rx_pe;
				end
			end
		end
	end

	// one shared request and wait wakeup; both frozen while halted so that a
	// pending event neither ends halt nor is lost when halt is left
	assign irq_d = global_irq_unmask && (
		(status_q[ST_TXE] && ctrl2_q[C2_TIE]) ||
		(status_q[ST_TC]  && ctrl2_q[C2_TX_DONE_IRQ_EN]) ||
		((status_q[ST_RXF] || status_q[ST_OR]) && ctrl2_q[C2_RIE]) ||
		(status_q[ST_IDLE] && ctrl2_q[C2_IDLE_IRQ_EN]) ||
		(status_q[ST_PE]  && ctrl1_q[C1_PIE]));
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end else if (!cpu_halt) begin
			irq_q  <= irq_d;
			wake_q <= irq_d;
		end
	end
endmodule : ustat_core

// ===== bench/ustat_core_sva.sv
/*
 * ustat_core_chk: port-level assertions and covers for ustat_core.
 * Assumes it is bound to each ustat_core instance and sees only its ports.
 */
`timescale 1ns/1ns
module ustat_core_chk (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cpu_halt,
	input wire logic        global_irq_unmask,
	input wire logic        rx_pin,
	input wire logic        tx_pin,
	input wire logic        irq_q,
	input wire logic        wake_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// bus answers exactly one cycle after setup and only for one cycle
	AST_READY_ONE: assert property (psel && !penable && !cpu_halt ##1 !cpu_halt |-> pready)
		else $error("no answer one cycle after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_SLVERR_MAP: assert property (pready |->
		(pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})))
		else $error("error response does not match address map");
	// interrupt gating and wait exit
	AST_IRQ_MASKED: assert property (!global_irq_unmask [*2] |-> !irq_q)
		else $error("interrupt raised while globally masked");
	AST_WAKE_FOLLOW: assert property (wake_q == irq_q)
		else $error("wake request differs from interrupt");
	// halt freezes the serial and interrupt outputs and blocks the bus
	AST_HALT_FREEZE: assert property (cpu_halt [*2] |-> $stable(tx_pin) && $stable(irq_q))
		else $error("outputs moved during halt");
	AST_HALT_NO_ANSWER: assert property (cpu_halt [*2] |-> !pready)
		else $error("bus answered during halt");
	// every low serial level lasts at least eight clocks
	AST_BIT_WIDTH: assert property ($fell(tx_pin) |-> !tx_pin [*8])
		else $error("serial low level too short");

	// main scenarios
	COV_IRQ: cover property ($rose(irq_q));
	COV_TX: cover property ($fell(tx_pin));
	COV_ERR: cover property (pready && pslverr);
endmodule : ustat_core_chk

bind ustat_core ustat_core_chk chk_u (
	.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cpu_halt(cpu_halt), .global_irq_unmask(global_irq_unmask), .rx_pin(rx_pin),
	.tx_pin(tx_pin), .irq_q(irq_q), .wake_q(wake_q)
);

// ===== bench/ustat_remote.sv
/*
 * ustat_remote: remote serial station, frames LSB first, line idle high.
 * Assumes a fixed bit time in core clocks that matches the dut divisor.
 */
`timescale 1ns/1ns
module ustat_remote #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic core_clk,
	input  wire logic line_in,
	output logic      line_out
);
	int         n_bits = 8;
	int         n_got  = 0;
	logic [8:0] got_q  = '0;

	initial line_out = 1'b1;

	// send one frame: start, data lsb first, stop
	task automatic send(input logic [8:0] w, input int nb);
		@(posedge core_clk);
		line_out <= 1'b0;
		repeat (BIT_CLKS) @(posedge core_clk);
		for (int i = 0; i < nb; i++) begin
			line_out <= w[i];
			repeat (BIT_CLKS) @(posedge core_clk);
		end
		line_out <= 1'b1;
		repeat (BIT_CLKS) @(posedge core_clk);
	endtask : send

	// receiver: sample the middle of every data bit
	always begin
		@(negedge line_in);
		got_q = '0;
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		for (int i = 0; i < n_bits; i++) begin
			repeat (BIT_CLKS) @(posedge core_clk);
			got_q[i] = line_in;
		end
		repeat (BIT_CLKS) @(posedge core_clk);
		n_got++;
	end
endmodule : ustat_remote

// ===== bench/tb_top.sv
/*
 * tb_top: self-checking bench for ustat_core over APB and the serial line.
 * Assumes baud divisor reset 1, so one bit lasts 32 core clocks.
 */
`timescale 1ns/1ns
module tb_top;
	import ustat_pkg::*;
	logic        core_clk, nrst, psel, penable, pwrite, cpu_halt, global_irq_unmask;
	logic        rx_pin, tx_pin, pready, pslverr, irq_q, wake_q;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic        err_q;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	ustat_core dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_halt(cpu_halt), .global_irq_unmask(global_irq_unmask),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .irq_q(irq_q), .wake_q(wake_q));
	ustat_remote partner_u (.core_clk(core_clk), .line_in(tx_pin), .line_out(rx_pin));

	// clock generator
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk);
		end
		if (n == 20)
			n_mismatch++;
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd_q & m, e);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle

	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (partner_u.n_got < n && k < 3000) begin
			k++;
			@(posedge core_clk);
		end
		if (k == 3000)
			n_mismatch++;
	endtask : wait_got

	// watchdog
	initial begin
		idle(30000);
		n_mismatch++;
		report_and_stop();
	end

	// test sequence
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_halt = 1'b0;
		global_irq_unmask = 1'b0;
		idle(20);
		nrst <= 1'b1;
		idle(3);
		rd(ADDR_STATUS, 32'hFFFFFFFF, 32'hC0);
		rd(ADDR_CTRL1, 32'hFFFFFFFF, 32'h00);
		rd(8'h20, 32'hFFFFFFFF, 32'h00);
		check(err_q, 1'b1);
		// transmit one 8-bit word
		apb(1'b1, ADDR_CTRL2, 32'h0C);
		apb(1'b0, ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_DATA, 32'hA5);
		wait_got(1);
		check({23'h0, partner_u.got_q}, 32'hA5);
		idle(40);
		rd(ADDR_STATUS, 32'hEF, 32'hC0);
		// tx empty and tx done interrupts, gated by global mask, frozen in halt
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ADDR_CTRL2, 32'h0C | (32'h80 >> i));
			idle(3);
			check(irq_q, 1'b0);
			global_irq_unmask <= 1'b1;
			idle(3);
			check({irq_q, wake_q}, 2'b11);
			cpu_halt <= 1'b1;
			idle(20);
			cpu_halt <= 1'b0;
			check(irq_q, 1'b1);
			global_irq_unmask <= 1'b0;
			idle(3);
		end
		global_irq_unmask <= 1'b1;
		apb(1'b1, ADDR_CTRL2, 32'h2C);
		idle(3);
		check(irq_q, 1'b0);
		// receive one 8-bit word
		partner_u.send(9'h03C, 8);
		idle(4);
		check(irq_q, 1'b1);
		rd(ADDR_STATUS, 32'h2F, 32'h20);
		rd(ADDR_DATA, 32'hFFFFFFFF, 32'h3C);
		idle(3);
		check(irq_q, 1'b0);
		rd(ADDR_STATUS, 32'h2F, 32'h00);
		// parity error with even parity in bit 7
		apb(1'b1, ADDR_CTRL2, 32'h0C);
		apb(1'b1, ADDR_CTRL1, 32'h05);
		rd(ADDR_CTRL1, 32'hFF, 32'h05);
		partner_u.send(9'h001, 8);
		idle(4);
		check(irq_q, 1'b1);
		rd(ADDR_STATUS, 32'h01, 32'h01);
		apb(1'b0, ADDR_DATA, 32'h0);
		rd(ADDR_STATUS, 32'h01, 32'h00);
		// nine-bit words both ways
		apb(1'b1, ADDR_CTRL1, 32'h50);
		partner_u.n_bits = 9;
		partner_u.send(9'h1AA, 9);
		idle(4);
		rd(ADDR_CTRL1, 32'hFF, 32'hD0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		rd(ADDR_DATA, 32'hFF, 32'hAA);
		apb(1'b0, ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_DATA, 32'h33);
		wait_got(2);
		check({23'h0, partner_u.got_q}, 32'h133);
		// a low ninth bit lands where an eight-bit frame wants its stop bit
		idle(40);
		apb(1'b1, ADDR_CTRL1, 32'h00);
		partner_u.send(9'h055, 9);
		rd(ADDR_STATUS, 32'h22, 32'h22);
		rd(ADDR_DATA, 32'hFF, 32'h55);
		rd(ADDR_STATUS, 32'h02, 32'h00);
		// low power holds a written byte until it is cleared again
		partner_u.n_bits = 8;
		apb(1'b1, ADDR_CTRL1, 32'h20);
		apb(1'b0, ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_DATA, 32'h5A);
		idle(400);
		check(partner_u.n_got, 2);
		apb(1'b1, ADDR_CTRL1, 32'h00);
		wait_got(3);
		check({23'h0, partner_u.got_q}, 32'h5A);
		report_and_stop();
	end
endmodule : tb_top
